// ==== core/gpib_cmd_pkg.sv ====
// constants and types shared by the gpib command decoder
package gpib_cmd_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_MASK    = 8'h04;
  localparam logic [7:0] OFS_CONFIG  = 8'h08;
  localparam logic [7:0] OFS_AUX     = 8'h0C;
  localparam logic [7:0] OFS_CMDPASS = 8'h10;

  // status and mask flag positions
  localparam int FLG_W    = 7;
  localparam int FLG_MA   = 0;
  localparam int FLG_MAC  = 1;
  localparam int FLG_APT  = 2;
  localparam int FLG_UNC  = 3;
  localparam int FLG_DC   = 4;
  localparam int FLG_TRIG = 5;
  localparam int FLG_RLC  = 6;

  // config fields
  localparam int CFG_W        = 6;
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_ADDR_W   = 5;
  localparam int CFG_CTRL_ACT = 5;

  // aux command bits, write only
  localparam int AUX_DACR = 0;
  localparam int AUX_PTS  = 1;

  // cmdpass state bit positions
  localparam int PASS_LADS = 8;
  localparam int PASS_TADS = 9;
  localparam int PASS_REM  = 10;
  localparam int PASS_HOLD = 11;

  // reset values
  localparam logic [FLG_W-1:0] STATUS_RST = 7'h00;
  localparam logic [FLG_W-1:0] MASK_RST   = 7'h00;
  localparam logic [CFG_W-1:0] CFG_RST    = 6'h00;
  localparam logic [10:0]      PIN_RST    = 11'h7FF;

  // command groups, bits 6..5 of the 7-bit command
  localparam logic [1:0] GRP_CMD    = 2'h0;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;
  localparam logic [1:0] GRP_SEC    = 2'h3;

  // command codes, bit 8 dropped, positive logic
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_PPC = 7'h05;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_TCT = 7'h09;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_PPU = 7'h15;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ACC_IDLE,
    ACC_READY,
    ACC_ACDS,
    ACC_HOLD,
    ACC_DONE
  } acc_state_type;

endpackage : gpib_cmd_pkg

// ==== core/gpib_pin_sync.sv ====
// three flop synchroniser that passes a bit once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module gpib_pin_sync #(
  parameter int          W   = 11,
  parameter logic [10:0] RST = gpib_cmd_pkg::PIN_RST
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] pin_i,
  output var  logic [W-1:0] level_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        s1_ff[i]   <= RST[i];
        s2_ff[i]   <= RST[i];
        s3_ff[i]   <= RST[i];
        level_o[i] <= RST[i];
      end else begin
        s1_ff[i] <= pin_i[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          level_o[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule : gpib_pin_sync
`default_nettype wire

// ==== core/gpib_command_decoder.sv ====
// gpib multiline command decoder with axi4-lite register access
// Contract
// - flags set in accept state, masked onto interrupt
// - addressed commands other than take control flag only while listener addressed
// - match listen, talk and secondary address forms
// - secondary address raises passthrough flag, holds off
// - parallel poll configure handled as unrecognized
// - pts write lets poll secondaries raise passthrough
// - parallel poll unconfigure unrecognized with holdoff
// - take control unrecognized only when talker addressed
// - remote/local change flag, go to local no holdoff
// - device clear sets clear flag with holdoff
// - selected device clear sets clear flag, holdoff
// - group execute trigger sets trigger flag, holdoff
// - my talk address sets address flags, holdoff
// - unlisten and other talk address: change flag only
// - lockout and serial poll commands do nothing
// - bus data negative logic, bit eight ignored
// - acceptor idle while controller function active
`timescale 1ns/10ps
`default_nettype none
module gpib_command_decoder (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        s_axi_awvalid_i,
  output var  logic        s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output var  logic        s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  output var  logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output var  logic [1:0]  s_axi_bresp_o,
  input  wire logic        s_axi_arvalid_i,
  output var  logic        s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  output var  logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output var  logic [31:0] s_axi_rdata_o,
  output var  logic [1:0]  s_axi_rresp_o,
  input  wire logic [7:0]  dio_n_i,
  input  wire logic        atn_n_i,
  input  wire logic        dav_n_i,
  input  wire logic        ren_n_i,
  output var  logic        ndac_n_o,
  output var  logic        ndac_oe_o,
  output var  logic        nrfd_n_o,
  output var  logic        nrfd_oe_o,
  output var  logic        int_n_o,
  output var  logic        int_oe_o
);
  logic [10:0]                          pins_s;
  logic [7:0]                           dio_n_s;
  logic                                 atn_true;
  logic                                 dav_true;
  logic                                 ren_true;
  gpib_cmd_pkg::acc_state_type          acc_state_ff;
  gpib_cmd_pkg::acc_state_type          nxt_acc_state;
  logic [6:0]                           cmd_ff;
  logic [gpib_cmd_pkg::FLG_W-1:0]       status_ff;
  logic [gpib_cmd_pkg::FLG_W-1:0]       mask_ff;
  logic [gpib_cmd_pkg::CFG_W-1:0]       cfg_ff;
  logic                                 lads_ff;
  logic                                 tads_ff;
  logic                                 remote_ff;
  logic                                 my_prim_ff;
  logic                                 pts_ff;
  logic                                 nxt_lads;
  logic                                 nxt_tads;
  logic                                 nxt_remote;
  logic                                 nxt_my_prim;
  logic                                 clr_pts;
  logic [gpib_cmd_pkg::FLG_W-1:0]       set_vec;
  logic                                 need_hold;
  logic                                 ctrl_act;
  logic                                 acc_ok;
  logic [1:0]                           grp;
  logic                                 my_addr;
  logic                                 aw_got_ff;
  logic                                 w_got_ff;
  logic [7:0]                           awaddr_ff;
  logic [31:0]                          wdata_ff;
  logic                                 wstrb0_ff;
  logic                                 wr_do;
  logic                                 wr_ok;
  logic [gpib_cmd_pkg::FLG_W-1:0]       clr_vec;
  logic                                 dacr_wr;
  logic                                 pts_wr;
  logic [31:0]                          rd_word;
  logic                                 rd_ok;

  gpib_pin_sync #(
    .W   (11),
    .RST (gpib_cmd_pkg::PIN_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .pin_i   ({ren_n_i, dav_n_i, atn_n_i, dio_n_i}),
    .level_o (pins_s)
  );

  assign dio_n_s  = pins_s[7:0];
  assign atn_true = ~pins_s[8];
  assign dav_true = ~pins_s[9];
  assign ren_true = ~pins_s[10];
  assign ctrl_act = cfg_ff[gpib_cmd_pkg::CFG_CTRL_ACT];
  assign acc_ok   = atn_true & ~ctrl_act;
  assign grp      = cmd_ff[6:5];
  assign my_addr  = cmd_ff[4:0] == cfg_ff[gpib_cmd_pkg::CFG_ADDR_LSB +: gpib_cmd_pkg::CFG_ADDR_W];

  // acceptor handshake
  always_comb begin
    nxt_acc_state = acc_state_ff;
    case (acc_state_ff)
      gpib_cmd_pkg::ACC_IDLE:  nxt_acc_state = gpib_cmd_pkg::ACC_READY;
      gpib_cmd_pkg::ACC_READY: begin
        if (dav_true) begin
          nxt_acc_state = gpib_cmd_pkg::ACC_ACDS;
        end
      end
      gpib_cmd_pkg::ACC_ACDS: begin
        nxt_acc_state = need_hold ? gpib_cmd_pkg::ACC_HOLD : gpib_cmd_pkg::ACC_DONE;
      end
      gpib_cmd_pkg::ACC_HOLD: begin
        if (dacr_wr) begin
          nxt_acc_state = gpib_cmd_pkg::ACC_DONE;
        end
      end
      gpib_cmd_pkg::ACC_DONE: begin
        if (!dav_true) begin
          nxt_acc_state = gpib_cmd_pkg::ACC_READY;
        end
      end
      default: nxt_acc_state = gpib_cmd_pkg::ACC_IDLE;
    endcase
    if (!acc_ok) begin
      nxt_acc_state = gpib_cmd_pkg::ACC_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_state_ff <= gpib_cmd_pkg::ACC_IDLE;
    end else begin
      acc_state_ff <= nxt_acc_state;
    end
  end

  // latch command, inverted from bus levels, bit 8 dropped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmd_ff <= 7'h00;
    end else if (acc_state_ff == gpib_cmd_pkg::ACC_READY && dav_true) begin
      cmd_ff <= ~dio_n_s[6:0];
    end
  end

  // line drivers: ndac low until accepted, nrfd low while busy
  assign ndac_n_o  = 1'b0;
  assign nrfd_n_o  = 1'b0;
  assign ndac_oe_o = acc_state_ff == gpib_cmd_pkg::ACC_READY ||
                     acc_state_ff == gpib_cmd_pkg::ACC_ACDS ||
                     acc_state_ff == gpib_cmd_pkg::ACC_HOLD;
  assign nrfd_oe_o = acc_state_ff == gpib_cmd_pkg::ACC_ACDS ||
                     acc_state_ff == gpib_cmd_pkg::ACC_HOLD ||
                     acc_state_ff == gpib_cmd_pkg::ACC_DONE;

  // command decode, acts only in the accept state
  always_comb begin
    set_vec     = '0;
    need_hold   = 1'b0;
    nxt_lads    = lads_ff;
    nxt_tads    = tads_ff;
    nxt_remote  = remote_ff & ren_true;
    nxt_my_prim = my_prim_ff;
    clr_pts     = 1'b0;
    if (acc_state_ff == gpib_cmd_pkg::ACC_ACDS) begin
      if (grp != gpib_cmd_pkg::GRP_SEC) begin
        nxt_my_prim = 1'b0;
        clr_pts     = 1'b1;
      end
      case (grp)
        gpib_cmd_pkg::GRP_CMD: begin
          if (cmd_ff[4]) begin
            if (cmd_ff == gpib_cmd_pkg::CMD_DCL) begin
              set_vec[gpib_cmd_pkg::FLG_DC] = 1'b1;
              need_hold                     = 1'b1;
            end else if (cmd_ff == gpib_cmd_pkg::CMD_PPU) begin
              set_vec[gpib_cmd_pkg::FLG_UNC] = 1'b1;
              need_hold                      = 1'b1;
            end
            // lockout, serial poll and other universals pass silently
          end else if (cmd_ff == gpib_cmd_pkg::CMD_TCT) begin
            if (tads_ff) begin
              set_vec[gpib_cmd_pkg::FLG_UNC] = 1'b1;
              need_hold                      = 1'b1;
            end
          end else if (lads_ff) begin
            if (cmd_ff == gpib_cmd_pkg::CMD_SDC) begin
              set_vec[gpib_cmd_pkg::FLG_DC] = 1'b1;
              need_hold                     = 1'b1;
            end else if (cmd_ff == gpib_cmd_pkg::CMD_GET) begin
              set_vec[gpib_cmd_pkg::FLG_TRIG] = 1'b1;
              need_hold                       = 1'b1;
            end else if (cmd_ff == gpib_cmd_pkg::CMD_GTL) begin
              if (remote_ff) begin
                nxt_remote                     = 1'b0;
                set_vec[gpib_cmd_pkg::FLG_RLC] = 1'b1;
              end
            end else begin
              set_vec[gpib_cmd_pkg::FLG_UNC] = 1'b1;
              need_hold                      = 1'b1;
            end
          end
        end
        gpib_cmd_pkg::GRP_LISTEN: begin
          if (cmd_ff == gpib_cmd_pkg::CMD_UNL) begin
            nxt_lads = 1'b0;
            if (lads_ff) begin
              set_vec[gpib_cmd_pkg::FLG_MAC] = 1'b1;
            end
          end else if (my_addr) begin
            nxt_lads                       = 1'b1;
            nxt_my_prim                    = 1'b1;
            set_vec[gpib_cmd_pkg::FLG_MA]  = 1'b1;
            set_vec[gpib_cmd_pkg::FLG_MAC] = ~lads_ff;
            need_hold                      = 1'b1;
            if (ren_true && !remote_ff) begin
              nxt_remote                     = 1'b1;
              set_vec[gpib_cmd_pkg::FLG_RLC] = 1'b1;
            end
          end
        end
        gpib_cmd_pkg::GRP_TALK: begin
          if (cmd_ff == gpib_cmd_pkg::CMD_UNT) begin
            nxt_tads = 1'b0;
          end else if (my_addr) begin
            nxt_tads                       = 1'b1;
            nxt_my_prim                    = 1'b1;
            set_vec[gpib_cmd_pkg::FLG_MA]  = 1'b1;
            set_vec[gpib_cmd_pkg::FLG_MAC] = 1'b1;
            need_hold                      = 1'b1;
          end else begin
            nxt_tads = 1'b0;
            if (lads_ff) begin
              set_vec[gpib_cmd_pkg::FLG_MAC] = 1'b1;
            end
          end
        end
        gpib_cmd_pkg::GRP_SEC: begin
          if (my_prim_ff || pts_ff) begin
            set_vec[gpib_cmd_pkg::FLG_APT] = 1'b1;
            need_hold                      = 1'b1;
          end
        end
        default: need_hold = 1'b0;
      endcase
    end
  end

  // addressing, remote and pass-through state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lads_ff    <= 1'b0;
      tads_ff    <= 1'b0;
      remote_ff  <= 1'b0;
      my_prim_ff <= 1'b0;
    end else begin
      lads_ff    <= nxt_lads;
      tads_ff    <= nxt_tads;
      remote_ff  <= nxt_remote;
      my_prim_ff <= nxt_my_prim;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pts_ff <= 1'b0;
    end else if (pts_wr) begin
      pts_ff <= 1'b1;
    end else if (clr_pts) begin
      pts_ff <= 1'b0;
    end
  end

  // sticky flags, a new event wins over a software clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_ff <= gpib_cmd_pkg::STATUS_RST;
    end else begin
      status_ff <= (status_ff & ~clr_vec) | set_vec;
    end
  end

  assign int_n_o  = 1'b0;
  assign int_oe_o = |(status_ff & mask_ff);

  // axi4-lite write path
  assign s_axi_awready_o = ~aw_got_ff & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_got_ff & ~s_axi_bvalid_o;
  assign wr_do   = aw_got_ff & w_got_ff & ~s_axi_bvalid_o;
  assign wr_ok   = awaddr_ff == gpib_cmd_pkg::OFS_STATUS || awaddr_ff == gpib_cmd_pkg::OFS_MASK ||
                   awaddr_ff == gpib_cmd_pkg::OFS_CONFIG || awaddr_ff == gpib_cmd_pkg::OFS_AUX;
  assign clr_vec = (wr_do && wstrb0_ff && awaddr_ff == gpib_cmd_pkg::OFS_STATUS) ?
                   wdata_ff[gpib_cmd_pkg::FLG_W-1:0] : '0;
  assign dacr_wr = wr_do & wstrb0_ff & (awaddr_ff == gpib_cmd_pkg::OFS_AUX) &
                   wdata_ff[gpib_cmd_pkg::AUX_DACR];
  assign pts_wr  = wr_do & wstrb0_ff & (awaddr_ff == gpib_cmd_pkg::OFS_AUX) &
                   wdata_ff[gpib_cmd_pkg::AUX_PTS];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= {s_axi_awaddr_i[7:2], 2'b00};
    end else if (wr_do) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      w_got_ff  <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_got_ff  <= 1'b1;
      wdata_ff  <= s_axi_wdata_i;
      wstrb0_ff <= s_axi_wstrb_i[0];
    end else if (wr_do) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= gpib_cmd_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_ok ? gpib_cmd_pkg::RESP_OKAY : gpib_cmd_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mask_ff <= gpib_cmd_pkg::MASK_RST;
      cfg_ff  <= gpib_cmd_pkg::CFG_RST;
    end else if (wr_do && wstrb0_ff) begin
      if (awaddr_ff == gpib_cmd_pkg::OFS_MASK) begin
        mask_ff <= wdata_ff[gpib_cmd_pkg::FLG_W-1:0];
      end
      if (awaddr_ff == gpib_cmd_pkg::OFS_CONFIG) begin
        cfg_ff <= wdata_ff[gpib_cmd_pkg::CFG_W-1:0];
      end
    end
  end

  // axi4-lite read path
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case ({s_axi_araddr_i[7:2], 2'b00})
      gpib_cmd_pkg::OFS_STATUS: rd_word[gpib_cmd_pkg::FLG_W-1:0] = status_ff;
      gpib_cmd_pkg::OFS_MASK:   rd_word[gpib_cmd_pkg::FLG_W-1:0] = mask_ff;
      gpib_cmd_pkg::OFS_CONFIG: rd_word[gpib_cmd_pkg::CFG_W-1:0] = cfg_ff;
      gpib_cmd_pkg::OFS_AUX:    rd_word = 32'h0000_0000;
      gpib_cmd_pkg::OFS_CMDPASS: begin
        rd_word[6:0]                    = cmd_ff;
        rd_word[gpib_cmd_pkg::PASS_LADS] = lads_ff;
        rd_word[gpib_cmd_pkg::PASS_TADS] = tads_ff;
        rd_word[gpib_cmd_pkg::PASS_REM]  = remote_ff;
        rd_word[gpib_cmd_pkg::PASS_HOLD] = acc_state_ff == gpib_cmd_pkg::ACC_HOLD;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready_o = ~s_axi_rvalid_o;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= gpib_cmd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_word;
      s_axi_rresp_o  <= rd_ok ? gpib_cmd_pkg::RESP_OKAY : gpib_cmd_pkg::RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // checks
  sequence seq_acds(logic [6:0] c);
    acc_state_ff == gpib_cmd_pkg::ACC_ACDS && cmd_ff == c && acc_ok;
  endsequence

  chk_flag_acds: assert property (@(posedge clk_i) disable iff (srst_i)
    (status_ff & ~$past(status_ff)) != '0 |-> $past(acc_state_ff) == gpib_cmd_pkg::ACC_ACDS)
    else $error("flag rose outside accept state");
  chk_int_mask: assert property (@(posedge clk_i) disable iff (srst_i)
    int_oe_o |-> (status_ff & mask_ff) != '0 && !int_n_o)
    else $error("interrupt driven without unmasked flag");
  chk_dcl_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    seq_acds(gpib_cmd_pkg::CMD_DCL) |=> acc_state_ff == gpib_cmd_pkg::ACC_HOLD
      && status_ff[gpib_cmd_pkg::FLG_DC])
    else $error("device clear missed flag or holdoff");
  chk_get_lads: assert property (@(posedge clk_i) disable iff (srst_i)
    seq_acds(gpib_cmd_pkg::CMD_GET) ##0 !lads_ff |=> acc_state_ff == gpib_cmd_pkg::ACC_DONE)
    else $error("trigger held off while not listener");
  chk_gtl_nohold: assert property (@(posedge clk_i) disable iff (srst_i)
    seq_acds(gpib_cmd_pkg::CMD_GTL) |=> acc_state_ff == gpib_cmd_pkg::ACC_DONE)
    else $error("go to local held off");
  chk_sec_apt: assert property (@(posedge clk_i) disable iff (srst_i)
    acc_state_ff == gpib_cmd_pkg::ACC_ACDS && grp == gpib_cmd_pkg::GRP_SEC && acc_ok
      && (my_prim_ff || pts_ff)
      |=> status_ff[gpib_cmd_pkg::FLG_APT] && acc_state_ff == gpib_cmd_pkg::ACC_HOLD)
    else $error("secondary not passed through");
  chk_quiet_cmds: assert property (@(posedge clk_i) disable iff (srst_i)
    (seq_acds(gpib_cmd_pkg::CMD_LLO) or seq_acds(gpib_cmd_pkg::CMD_SPE)
      or seq_acds(gpib_cmd_pkg::CMD_SPD)) |=> acc_state_ff == gpib_cmd_pkg::ACC_DONE
      && (status_ff & ~$past(status_ff)) == '0)
    else $error("quiet command raised flag or holdoff");
  chk_tct_tads: assert property (@(posedge clk_i) disable iff (srst_i)
    seq_acds(gpib_cmd_pkg::CMD_TCT) |=> (acc_state_ff == gpib_cmd_pkg::ACC_HOLD) == $past(tads_ff))
    else $error("take control holdoff not tied to talker state");
  chk_ctrl_idle: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_act ##1 ctrl_act |-> acc_state_ff == gpib_cmd_pkg::ACC_IDLE && !ndac_oe_o && !nrfd_oe_o)
    else $error("acceptor active under controller");
  chk_no_atn: assert property (@(posedge clk_i) disable iff (srst_i)
    !atn_true |=> acc_state_ff == gpib_cmd_pkg::ACC_IDLE)
    else $error("acceptor active without attention");
  chk_release: assert property (@(posedge clk_i) disable iff (srst_i)
    acc_state_ff == gpib_cmd_pkg::ACC_HOLD && dacr_wr && acc_ok
      |=> acc_state_ff == gpib_cmd_pkg::ACC_DONE ##1 !ndac_oe_o)
    else $error("holdoff not released");
endmodule : gpib_command_decoder
`default_nettype wire

// ==== bench/gpib_ctl_model.sv ====
// bus controller model: sends command bytes with the handshake
`timescale 1ns/10ps
`default_nettype none
module gpib_ctl_model (
  input  wire logic       clk_i,
  input  wire logic       ndac_oe_i,
  input  wire logic       nrfd_oe_i,
  output var  logic [7:0] dio_n_o,
  output var  logic       atn_n_o,
  output var  logic       dav_n_o,
  output var  logic       ren_n_o
);
  initial begin
    dio_n_o = 8'hff;
    atn_n_o = 1'b1;
    dav_n_o = 1'b1;
    ren_n_o = 1'b0;
  end
  task automatic offer(input logic [7:0] b, input logic atn);
    dio_n_o <= ~b;
    atn_n_o <= ~atn;
    repeat (6) @(posedge clk_i);
    while (nrfd_oe_i) @(posedge clk_i);
    dav_n_o <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask : offer
  // released lines return to the pull-up level
  task automatic done();
    while (ndac_oe_i) @(posedge clk_i);
    dav_n_o <= 1'b1;
    @(posedge clk_i);
    dio_n_o <= 8'hff;
  endtask : done
endmodule : gpib_ctl_model
`default_nettype wire

// ==== bench/gpib_command_decoder_tb_top.sv ====
// self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none
module gpib_command_decoder_tb_top;
  logic        clk_i, awr, wrd, bv, arr, rv, ndac_oe, nrfd_oe, int_oe, atn_n, dav_n, ren_n;
  logic        srst_i = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, dio_n;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic [1:0]  bresp, rresp;
  int          mismatches, n_tests;
  // byte, flags, aux write, attention
  logic [23:0] tbl [23] = '{24'ha543_11, 24'h0820_11, 24'h0410_11, 24'h0508_31,
    24'h6004_11, 24'h7004_11, 24'h1410_11, 24'h1508_11, 24'h1100_01,
    24'h1800_01, 24'h1900_01, 24'h0140_01, 24'h3f02_01, 24'h0800_01,
    24'h0900_01, 24'h4503_11, 24'h6104_11, 24'h0908_11,
    24'ha543_11, 24'h4602_01, 24'h5f00_01, 24'h6100_01, 24'h0800_00};
  gpib_command_decoder u_dut (.clk_i(clk_i), .srst_i(srst_i), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
    .dio_n_i(dio_n), .atn_n_i(atn_n), .dav_n_i(dav_n), .ren_n_i(ren_n), .ndac_n_o(),
    .ndac_oe_o(ndac_oe), .nrfd_n_o(), .nrfd_oe_o(nrfd_oe), .int_n_o(), .int_oe_o(int_oe));
  gpib_ctl_model u_ctl (.clk_i(clk_i), .ndac_oe_i(ndac_oe), .nrfd_oe_i(nrfd_oe),
    .dio_n_o(dio_n), .atn_n_o(atn_n), .dav_n_o(dav_n), .ren_n_o(ren_n));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    rr <= 1'b0;
    @(posedge clk_i);
  endtask : rd
  task automatic t_regs();
    logic [31:0] d;
    rd(8'h04, d);
    chk(d, 32'h0000_0000);
    rd(8'h1c, d);
    chk(rresp, gpib_cmd_pkg::RESP_SLVERR);
    wr(8'h1c, 32'h0000_0001);
    chk(bresp, gpib_cmd_pkg::RESP_SLVERR);
    wr(8'h04, 32'h0000_007f);
    chk(bresp, gpib_cmd_pkg::RESP_OKAY);
    rd(8'h04, d);
    chk(d, 32'h0000_007f);
    wr(8'h08, 32'h0000_0005);
    rd(8'h08, d);
    chk(d, 32'h0000_0005);
  endtask : t_regs
  task automatic t_cmds();
    logic [31:0] d;
    logic [23:0] e;
    foreach (tbl[i]) begin
      e = tbl[i];
      wr(8'h00, 32'h0000_007f);
      u_ctl.offer(e[23:16], e[0]);
      chk(ndac_oe, e[4]);
      chk(nrfd_oe, e[0]);
      rd(8'h00, d);
      chk(d, {24'h00_0000, e[15:8]});
      chk(int_oe, e[15:8] != 8'h00);
      rd(8'h10, d);
      chk(d[11], e[4]);
      if (e[7:4] != 4'h0) wr(8'h0c, {28'h000_0000, e[7:4]});
      u_ctl.done();
    end
  endtask : t_cmds
  task automatic t_ctrl();
    logic [31:0] d;
    wr(8'h08, 32'h0000_0025);
    u_ctl.offer(8'h08, 1'b1);
    chk(ndac_oe, 1'b0);
    rd(8'h00, d);
    chk(d, 32'h0000_0000);
    u_ctl.done();
  endtask : t_ctrl
  task automatic tally_and_finish();
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_cmds();
    t_ctrl();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end
endmodule : gpib_command_decoder_tb_top
`default_nettype wire
